// *** src/instruction_format_decoder.sv ***
// registered decoder splitting 16-bit instruction words into format class and operand fields
`timescale 1ns/1ns
`default_nettype none
`include "instruction_format_decoder_map.svh"

// Notes on behaviour
// - single-source format: bits 11..8 are source; direct, post-inc, indirect or pc-offset
// - long-branch format: top four bits opcode, low twelve bits displacement, pc relative
// - single-destination format: control source for the sts/stc forms only; destination direct or pre-decrement indirect
// - multiply-accumulate: destination field is second post-inc source; result to accum pair
// - long-branch displacement is sign-extended, doubled, then added to pc
// - pc-relative longword loads clear the two low pc bits before adding
// - trap immediate is zero-extended and multiplied by four for the vector offset
// - move, add and compare-equal immediates are sign-extended before use
module instruction_format_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] pc,
  output logic dec_valid,
  output instruction_format_decoder_pkg::format_t dec_format,
  output logic [15:0] dec_word,
  output logic [3:0] src_reg,
  output logic [3:0] dst_reg,
  output instruction_format_decoder_pkg::operand_t src_mode,
  output instruction_format_decoder_pkg::operand_t dst_mode,
  output logic second_src_post_inc,
  output logic multiply_accum_high_we,
  output logic multiply_accum_low_we,
  output logic [3:0] disp4,
  output logic [7:0] disp8,
  output logic [11:0] disp12,
  output logic [7:0] imm8,
  output logic [31:0] imm_value,
  output logic [31:0] trap_always_offset,
  output logic [31:0] branch_target,
  output logic [31:0] pc_operand_addr
);

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_core_n;

  // reset enters asynchronously but is released through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_core_n = rst_sync2_q;

  // format class from the fixed opcode bits only; fields are not consulted
  function automatic instruction_format_decoder_pkg::format_t classify(input logic [15:0] w);
    logic [3:0] top;
    logic [3:0] sub;
    logic [3:0] mid;
    logic [3:0] low;
    top = w[`IFD_TOP_HI:`IFD_TOP_LO];
    sub = w[`IFD_N_HI:`IFD_N_LO];
    mid = w[`IFD_M_HI:`IFD_M_LO];
    low = w[`IFD_LOW_HI:`IFD_LOW_LO];
    case (top)
      `IFD_GRP_SYS: begin
        if (low == `IFD_LOW_STC || low == `IFD_LOW_STS) classify = instruction_format_decoder_pkg::FMT_N;
        else if (low == `IFD_LOW_MOVT && mid == `IFD_MID_MOVT) classify = instruction_format_decoder_pkg::FMT_N;
        else if (low == `IFD_LOW_STC_LONG) classify = instruction_format_decoder_pkg::FMT_M;
        else if (low >= 4'h4 && low != 4'h8 && low != 4'h9 && low != 4'hb)
          classify = instruction_format_decoder_pkg::FMT_NM;
        else classify = instruction_format_decoder_pkg::FMT_ZERO;
      end
      `IFD_GRP_ST_DISP, `IFD_GRP_LD_DISP: classify = instruction_format_decoder_pkg::FMT_NMD;
      `IFD_GRP_STORE, `IFD_GRP_ARITH, `IFD_GRP_MOVE: classify = instruction_format_decoder_pkg::FMT_NM;
      `IFD_GRP_SHIFT: begin
        if (low == `IFD_LOW_MAC || low == 4'hc || low == 4'hd)
          classify = instruction_format_decoder_pkg::FMT_NM;
        else if (low == `IFD_LOW_LDS_LONG || low == `IFD_LOW_LDC_LONG || low == `IFD_LOW_STS ||
                 low == `IFD_LOW_LDC || (low == `IFD_LOW_JUMP && mid != 4'h1))
          classify = instruction_format_decoder_pkg::FMT_M;
        else classify = instruction_format_decoder_pkg::FMT_N;
      end
      `IFD_GRP_ADD_IMM, `IFD_GRP_MOV_IMM: classify = instruction_format_decoder_pkg::FMT_NI;
      `IFD_GRP_BYTE: begin
        if (sub[3:1] == 3'b000) classify = instruction_format_decoder_pkg::FMT_ND4;
        else if (sub[3:1] == 3'b010) classify = instruction_format_decoder_pkg::FMT_MD;
        else if (sub == `IFD_SUB_CMP_EQ_IMM) classify = instruction_format_decoder_pkg::FMT_I;
        else classify = instruction_format_decoder_pkg::FMT_D;
      end
      `IFD_GRP_PC_WORD, `IFD_GRP_PC_LONG: classify = instruction_format_decoder_pkg::FMT_ND8;
      `IFD_GRP_BRA, `IFD_GRP_BSR: classify = instruction_format_decoder_pkg::FMT_D12;
      `IFD_GRP_GBR: begin
        if (sub[3] || sub == `IFD_SUB_TRAP_ALWAYS) classify = instruction_format_decoder_pkg::FMT_I;
        else classify = instruction_format_decoder_pkg::FMT_D;
      end
      default: classify = instruction_format_decoder_pkg::FMT_NM;
    endcase
  endfunction : classify

  instruction_format_decoder_pkg::format_t fmt;
  instruction_format_decoder_pkg::operand_t src_d;
  instruction_format_decoder_pkg::operand_t dst_d;
  logic [3:0] top;
  logic [3:0] sub;
  logic [3:0] mid;
  logic [3:0] low;
  logic is_mac;
  logic imm_signed;
  logic [31:0] imm_ext;
  logic [31:0] trap_off;
  logic [31:0] far_tgt;
  logic [31:0] near_tgt;
  logic [31:0] long_addr;
  logic [31:0] word_addr;
  logic [31:0] tgt_d;
  logic [31:0] pcop_d;

  assign fmt = classify(instr_word);
  assign top = instr_word[`IFD_TOP_HI:`IFD_TOP_LO];
  assign sub = instr_word[`IFD_N_HI:`IFD_N_LO];
  assign mid = instr_word[`IFD_M_HI:`IFD_M_LO];
  assign low = instr_word[`IFD_LOW_HI:`IFD_LOW_LO];
  assign is_mac = (fmt == instruction_format_decoder_pkg::FMT_NM) && (low == `IFD_LOW_MAC) &&
                  (top == `IFD_GRP_SYS || top == `IFD_GRP_SHIFT);
  assign imm_signed = (top == `IFD_GRP_MOV_IMM) || (top == `IFD_GRP_ADD_IMM) ||
                      (top == `IFD_GRP_BYTE && sub == `IFD_SUB_CMP_EQ_IMM);

  operand_extender u_ext (
    .pc(pc),
    .imm8(instr_word[7:0]),
    .disp8(instr_word[7:0]),
    .disp12(instr_word[11:0]),
    .imm_signed(imm_signed),
    .imm_ext(imm_ext),
    .trap_vec_offset(trap_off),
    .branch_far_target(far_tgt),
    .branch_near_target(near_tgt),
    .pc_long_addr(long_addr),
    .pc_word_addr(word_addr)
  );

  // operand roles per format class
  always_comb begin
    src_d = instruction_format_decoder_pkg::OPND_NONE;
    dst_d = instruction_format_decoder_pkg::OPND_NONE;
    case (fmt)
      instruction_format_decoder_pkg::FMT_ZERO: begin
      end
      instruction_format_decoder_pkg::FMT_N: begin
        dst_d = instruction_format_decoder_pkg::OPND_REG;
        if (top == `IFD_GRP_SYS && low != `IFD_LOW_MOVT)
          src_d = instruction_format_decoder_pkg::OPND_CTRL_SYS;
        if (top == `IFD_GRP_SHIFT && (low == `IFD_LOW_STC || low == `IFD_LOW_STC_LONG)) begin
          src_d = instruction_format_decoder_pkg::OPND_CTRL_SYS;
          dst_d = instruction_format_decoder_pkg::OPND_PRE_DEC;
        end
      end
      instruction_format_decoder_pkg::FMT_M: begin
        dst_d = instruction_format_decoder_pkg::OPND_CTRL_SYS;
        if (top == `IFD_GRP_SYS) begin
          src_d = instruction_format_decoder_pkg::OPND_PC_REL_REG;
          dst_d = instruction_format_decoder_pkg::OPND_NONE;
        end else if (low == `IFD_LOW_LDS_LONG || low == `IFD_LOW_LDC_LONG) begin
          src_d = instruction_format_decoder_pkg::OPND_POST_INC;
        end else if (low == `IFD_LOW_JUMP) begin
          src_d = instruction_format_decoder_pkg::OPND_INDIRECT;
          dst_d = instruction_format_decoder_pkg::OPND_NONE;
        end else begin
          src_d = instruction_format_decoder_pkg::OPND_REG;
        end
      end
      instruction_format_decoder_pkg::FMT_NM: begin
        src_d = instruction_format_decoder_pkg::OPND_REG;
        dst_d = instruction_format_decoder_pkg::OPND_REG;
        if (is_mac) begin
          src_d = instruction_format_decoder_pkg::OPND_POST_INC;
          dst_d = instruction_format_decoder_pkg::OPND_ACCUM;
        end else if (top == `IFD_GRP_STORE) begin
          dst_d = low[2] ? instruction_format_decoder_pkg::OPND_PRE_DEC :
                           instruction_format_decoder_pkg::OPND_INDIRECT;
        end else if (top == `IFD_GRP_MOVE && low[3:2] == 2'b01) begin
          src_d = instruction_format_decoder_pkg::OPND_POST_INC;
        end else if (top == `IFD_GRP_SYS && low[3:2] == 2'b01) begin
          dst_d = instruction_format_decoder_pkg::OPND_INDEX_R0;
        end
      end
      instruction_format_decoder_pkg::FMT_MD: begin
        src_d = instruction_format_decoder_pkg::OPND_REG_DISP;
        dst_d = instruction_format_decoder_pkg::OPND_R0;
      end
      instruction_format_decoder_pkg::FMT_ND4: begin
        src_d = instruction_format_decoder_pkg::OPND_R0;
        dst_d = instruction_format_decoder_pkg::OPND_REG_DISP;
      end
      instruction_format_decoder_pkg::FMT_NMD: begin
        src_d = (top == `IFD_GRP_ST_DISP) ? instruction_format_decoder_pkg::OPND_REG :
                                            instruction_format_decoder_pkg::OPND_REG_DISP;
        dst_d = (top == `IFD_GRP_ST_DISP) ? instruction_format_decoder_pkg::OPND_REG_DISP :
                                            instruction_format_decoder_pkg::OPND_REG;
      end
      instruction_format_decoder_pkg::FMT_D: begin
        if (top == `IFD_GRP_BYTE) begin
          dst_d = instruction_format_decoder_pkg::OPND_PC_REL;
        end else if (sub == `IFD_SUB_MOVA) begin
          src_d = instruction_format_decoder_pkg::OPND_PC_DISP;
          dst_d = instruction_format_decoder_pkg::OPND_R0;
        end else if (sub[2]) begin
          src_d = instruction_format_decoder_pkg::OPND_GBR_DISP;
          dst_d = instruction_format_decoder_pkg::OPND_R0;
        end else begin
          src_d = instruction_format_decoder_pkg::OPND_R0;
          dst_d = instruction_format_decoder_pkg::OPND_GBR_DISP;
        end
      end
      instruction_format_decoder_pkg::FMT_D12: begin
        dst_d = instruction_format_decoder_pkg::OPND_PC_REL;
      end
      instruction_format_decoder_pkg::FMT_ND8: begin
        src_d = instruction_format_decoder_pkg::OPND_PC_DISP;
        dst_d = instruction_format_decoder_pkg::OPND_REG;
      end
      instruction_format_decoder_pkg::FMT_I: begin
        src_d = instruction_format_decoder_pkg::OPND_IMM;
        if (top == `IFD_GRP_BYTE || sub[3:2] == 2'b10)
          dst_d = instruction_format_decoder_pkg::OPND_R0;
        else if (sub[3:2] == 2'b11)
          dst_d = instruction_format_decoder_pkg::OPND_INDEX_R0;
      end
      instruction_format_decoder_pkg::FMT_NI: begin
        src_d = instruction_format_decoder_pkg::OPND_IMM;
        dst_d = instruction_format_decoder_pkg::OPND_REG;
      end
      default: begin
      end
    endcase
  end

  // short branches use the 8-bit field, long ones the 12-bit field
  always_comb begin
    tgt_d = 32'h0000_0000;
    if (fmt == instruction_format_decoder_pkg::FMT_D12)
      tgt_d = far_tgt;
    else if (fmt == instruction_format_decoder_pkg::FMT_D && top == `IFD_GRP_BYTE)
      tgt_d = near_tgt;
  end

  always_comb begin
    pcop_d = 32'h0000_0000;
    if (top == `IFD_GRP_PC_LONG || (top == `IFD_GRP_GBR && sub == `IFD_SUB_MOVA))
      pcop_d = long_addr;
    else if (top == `IFD_GRP_PC_WORD)
      pcop_d = word_addr;
  end

  always_ff @(posedge clk_sys or negedge rst_core_n) begin
    if (!rst_core_n) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= instr_valid;
    end
  end

  // fields hold their last value while no word is offered
  always_ff @(posedge clk_sys or negedge rst_core_n) begin
    if (!rst_core_n) begin
      dec_format <= instruction_format_decoder_pkg::FMT_ZERO;
      dec_word <= `IFD_RESET_WORD;
      src_reg <= 4'h0;
      dst_reg <= 4'h0;
      src_mode <= instruction_format_decoder_pkg::OPND_NONE;
      dst_mode <= instruction_format_decoder_pkg::OPND_NONE;
      second_src_post_inc <= 1'b0;
      multiply_accum_high_we <= 1'b0;
      multiply_accum_low_we <= 1'b0;
      disp4 <= 4'h0;
      disp8 <= 8'h00;
      disp12 <= 12'h000;
      imm8 <= 8'h00;
      imm_value <= 32'h0000_0000;
      trap_always_offset <= 32'h0000_0000;
      branch_target <= 32'h0000_0000;
      pc_operand_addr <= 32'h0000_0000;
    end else if (instr_valid) begin
      dec_format <= fmt;
      dec_word <= instr_word;
      // single-source format carries its register in bits 11..8
      src_reg <= (fmt == instruction_format_decoder_pkg::FMT_M) ? sub : mid;
      dst_reg <= sub;
      src_mode <= src_d;
      dst_mode <= dst_d;
      second_src_post_inc <= is_mac;
      multiply_accum_high_we <= is_mac;
      multiply_accum_low_we <= is_mac;
      disp4 <= low;
      disp8 <= instr_word[7:0];
      disp12 <= instr_word[11:0];
      imm8 <= instr_word[7:0];
      imm_value <= imm_ext;
      trap_always_offset <= (fmt == instruction_format_decoder_pkg::FMT_I) ? trap_off :
                            32'h0000_0000;
      branch_target <= tgt_d;
      pc_operand_addr <= pcop_d;
    end
  end

endmodule : instruction_format_decoder
`default_nettype wire

// *** src/instruction_format_decoder_map.svh ***
// opcode bit positions, format selection codes and extension constants for the decoder
`ifndef INSTRUCTION_FORMAT_DECODER_MAP_SVH
`define INSTRUCTION_FORMAT_DECODER_MAP_SVH

`define IFD_INSTR_W 16
`define IFD_ADDR_W 32
// opcode and operand field positions
`define IFD_TOP_HI 15
`define IFD_TOP_LO 12
`define IFD_N_HI 11
`define IFD_N_LO 8
`define IFD_M_HI 7
`define IFD_M_LO 4
`define IFD_LOW_HI 3
`define IFD_LOW_LO 0
// top-nibble group codes
`define IFD_GRP_SYS 4'h0
`define IFD_GRP_ST_DISP 4'h1
`define IFD_GRP_STORE 4'h2
`define IFD_GRP_ARITH 4'h3
`define IFD_GRP_SHIFT 4'h4
`define IFD_GRP_LD_DISP 4'h5
`define IFD_GRP_MOVE 4'h6
`define IFD_GRP_ADD_IMM 4'h7
`define IFD_GRP_BYTE 4'h8
`define IFD_GRP_PC_WORD 4'h9
`define IFD_GRP_BRA 4'ha
`define IFD_GRP_BSR 4'hb
`define IFD_GRP_GBR 4'hc
`define IFD_GRP_PC_LONG 4'hd
`define IFD_GRP_MOV_IMM 4'he
// sub-codes inside the groups
`define IFD_SUB_CMP_EQ_IMM 4'h8
`define IFD_SUB_TRAP_ALWAYS 4'h3
`define IFD_SUB_MOVA 4'h7
`define IFD_LOW_STC 4'h2
`define IFD_LOW_STC_LONG 4'h3
`define IFD_LOW_LDS_LONG 4'h6
`define IFD_LOW_LDC_LONG 4'h7
`define IFD_LOW_STS 4'ha
`define IFD_LOW_JUMP 4'hb
`define IFD_LOW_LDC 4'he
`define IFD_LOW_MAC 4'hf
`define IFD_LOW_MOVT 4'h9
`define IFD_MID_MOVT 4'h2
// scaling shifts, longword pc mask and reset word
`define IFD_BRANCH_SHIFT 1
`define IFD_TRAP_SHIFT 2
`define IFD_LONG_SHIFT 2
`define IFD_PC_LONG_MASK 32'hffff_fffc
`define IFD_RESET_WORD 16'h0009

`endif

// *** src/instruction_format_decoder_pkg.sv ***
// types shared by the instruction format decoder
package instruction_format_decoder_pkg;

  typedef enum logic [11:0] {
    FMT_ZERO = 12'h001,
    FMT_N    = 12'h002,
    FMT_M    = 12'h004,
    FMT_NM   = 12'h008,
    FMT_MD   = 12'h010,
    FMT_ND4  = 12'h020,
    FMT_NMD  = 12'h040,
    FMT_D    = 12'h080,
    FMT_D12  = 12'h100,
    FMT_ND8  = 12'h200,
    FMT_I    = 12'h400,
    FMT_NI   = 12'h800
  } format_t;

  typedef enum logic [3:0] {
    OPND_NONE       = 4'h0,
    OPND_REG        = 4'h1,
    OPND_INDIRECT   = 4'h2,
    OPND_POST_INC   = 4'h3,
    OPND_PRE_DEC    = 4'h4,
    OPND_INDEX_R0   = 4'h5,
    OPND_REG_DISP   = 4'h6,
    OPND_GBR_DISP   = 4'h7,
    OPND_PC_DISP    = 4'h8,
    OPND_PC_REL     = 4'h9,
    OPND_PC_REL_REG = 4'ha,
    OPND_CTRL_SYS   = 4'hb,
    OPND_IMM        = 4'hc,
    OPND_R0         = 4'hd,
    OPND_ACCUM      = 4'he
  } operand_t;

endpackage : instruction_format_decoder_pkg

// *** src/operand_extender.sv ***
// sign/zero extension and scaling of displacement and immediate fields
`timescale 1ns/1ns
`default_nettype none
`include "instruction_format_decoder_map.svh"

module operand_extender (
  input wire logic [31:0] pc,
  input wire logic [7:0] imm8,
  input wire logic [7:0] disp8,
  input wire logic [11:0] disp12,
  input wire logic imm_signed,
  output logic [31:0] imm_ext,
  output logic [31:0] trap_vec_offset,
  output logic [31:0] branch_far_target,
  output logic [31:0] branch_near_target,
  output logic [31:0] pc_long_addr,
  output logic [31:0] pc_word_addr
);

  logic [31:0] sext12;
  logic [31:0] sext8;
  logic [31:0] zext8;

  assign sext12 = {{20{disp12[11]}}, disp12};
  assign sext8 = {{24{disp8[7]}}, disp8};
  assign zext8 = {24'h00_0000, disp8};

  // sign-extend or zero-extend the immediate by instruction class
  assign imm_ext = imm_signed ? {{24{imm8[7]}}, imm8} : {24'h00_0000, imm8};
  assign trap_vec_offset = {22'h00_0000, imm8, 2'b00};
  assign branch_far_target = pc + (sext12 << `IFD_BRANCH_SHIFT);
  assign branch_near_target = pc + (sext8 << `IFD_BRANCH_SHIFT);
  // low pc bits cleared so longword literals stay aligned
  assign pc_long_addr = (pc & `IFD_PC_LONG_MASK) + (zext8 << `IFD_LONG_SHIFT);
  assign pc_word_addr = pc + (zext8 << `IFD_BRANCH_SHIFT);

endmodule : operand_extender
`default_nettype wire

// *** tb/decoder_assertions.sv ***
// concurrent checks on the decoder top-level ports
`timescale 1ns/1ns
`default_nettype none
module decoder_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] pc,
  input wire logic dec_valid,
  input wire instruction_format_decoder_pkg::format_t dec_format,
  input wire logic [15:0] dec_word,
  input wire logic [3:0] src_reg,
  input wire logic [3:0] dst_reg,
  input wire instruction_format_decoder_pkg::operand_t src_mode,
  input wire instruction_format_decoder_pkg::operand_t dst_mode,
  input wire logic second_src_post_inc,
  input wire logic multiply_accum_high_we,
  input wire logic multiply_accum_low_we,
  input wire logic [11:0] disp12,
  input wire logic [31:0] imm_value,
  input wire logic [31:0] trap_always_offset,
  input wire logic [31:0] branch_target,
  input wire logic [31:0] pc_operand_addr
);
  logic multiply_accumulate_word;
  assign multiply_accumulate_word = (instr_word[15:12] == 4'h0 || instr_word[15:12] == 4'h4) && instr_word[3:0] == 4'hf;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_word;
    instr_valid |=> dec_valid && dec_word == $past(instr_word);
  endproperty
  a_word: assert property (p_word) else $error("decoded word not the accepted one");
  property p_idle;
    !instr_valid |=> !dec_valid && $stable(dec_word);
  endproperty
  a_idle: assert property (p_idle) else $error("moved while idle");
  property p_src;
    instr_valid && instr_word[15:12] == 4'h4 && instr_word[3:1] == 3'h3 |=>
      dec_format == instruction_format_decoder_pkg::FMT_M && src_reg == $past(instr_word[11:8])
      && src_mode == instruction_format_decoder_pkg::OPND_POST_INC;
  endproperty
  a_src: assert property (p_src) else $error("single source field wrong");
  property p_d12;
    instr_valid && instr_word[15:12] == 4'ha |=> dec_format == instruction_format_decoder_pkg::FMT_D12
      && disp12 == $past(instr_word[11:0]);
  endproperty
  a_d12: assert property (p_d12) else $error("long branch field wrong");
  property p_ctrl;
    instr_valid && instr_word[15:12] == 4'h4 && instr_word[3:0] == 4'h3 |=>
      src_mode == instruction_format_decoder_pkg::OPND_CTRL_SYS && dst_reg == $past(instr_word[11:8])
      && dst_mode == instruction_format_decoder_pkg::OPND_PRE_DEC;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control store roles wrong");
  property p_mac;
    instr_valid |=> second_src_post_inc == $past(multiply_accumulate_word) && multiply_accum_high_we == $past(multiply_accumulate_word)
      && multiply_accum_low_we == $past(multiply_accumulate_word);
  endproperty
  a_mac: assert property (p_mac) else $error("mac controls wrong");
  property p_bra;
    instr_valid && instr_word[15:12] == 4'ha |=> branch_target ==
      $past(pc) + {{19{$past(instr_word[11])}}, $past(instr_word[11:0]), 1'b0};
  endproperty
  a_bra: assert property (p_bra) else $error("branch target wrong");
  property p_pcl;
    instr_valid && instr_word[15:12] == 4'hd |=> pc_operand_addr ==
      ($past(pc) & 32'hffff_fffc) + {22'h0, $past(instr_word[7:0]), 2'h0};
  endproperty
  a_pcl: assert property (p_pcl) else $error("longword pc address wrong");
  property p_trap;
    instr_valid && instr_word[15:8] == 8'hc3 |=> trap_always_offset ==
      {22'h0, $past(instr_word[7:0]), 2'h0};
  endproperty
  a_trap: assert property (p_trap) else $error("trap offset wrong");
  property p_imm;
    instr_valid && instr_word[15:12] == 4'he |=> imm_value ==
      {{24{$past(instr_word[7])}}, $past(instr_word[7:0])};
  endproperty
  a_imm: assert property (p_imm) else $error("imm not signed");
endmodule : decoder_assertions
bind instruction_format_decoder decoder_assertions i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .instr_valid(instr_valid), .instr_word(instr_word), .pc(pc), .dec_valid(dec_valid),
  .dec_format(dec_format), .dec_word(dec_word), .src_reg(src_reg), .dst_reg(dst_reg),
  .src_mode(src_mode), .dst_mode(dst_mode), .second_src_post_inc(second_src_post_inc),
  .multiply_accum_high_we(multiply_accum_high_we), .multiply_accum_low_we(multiply_accum_low_we),
  .disp12(disp12), .imm_value(imm_value), .trap_always_offset(trap_always_offset),
  .branch_target(branch_target), .pc_operand_addr(pc_operand_addr));
`default_nettype wire

// *** tb/fetch_model.sv ***
// fetch-side model handing 16-bit words and their pc to the decoder
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [15:0] req_word,
  input wire logic [31:0] req_pc,
  output logic instr_valid,
  output logic [15:0] instr_word,
  output logic [31:0] pc
);
  // idle cycles flip word and pc so stale data never looks held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0;
      pc <= 32'h0;
    end else if (req) begin
      instr_valid <= 1'b1;
      instr_word <= req_word;
      pc <= req_pc;
    end else begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
      pc <= ~pc;
    end
  end
endmodule : fetch_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the instruction format decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys, rst_n, req, instr_valid, dec_valid, second_src_post_inc;
  logic multiply_accum_high_we, multiply_accum_low_we;
  logic [15:0] req_word, instr_word, dec_word;
  logic [31:0] req_pc, pc, imm_value, trap_always_offset, branch_target, pc_operand_addr;
  logic [3:0] src_reg, dst_reg, disp4;
  logic [7:0] disp8, imm8;
  logic [11:0] disp12;
  instruction_format_decoder_pkg::format_t dec_format;
  instruction_format_decoder_pkg::operand_t src_mode, dst_mode;
  int bad_count = 0;
  int checked = 0;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  fetch_model i_fetch (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .req_word(req_word),
    .req_pc(req_pc), .instr_valid(instr_valid), .instr_word(instr_word), .pc(pc));
  instruction_format_decoder i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .pc(pc), .dec_valid(dec_valid), .dec_format(dec_format),
    .dec_word(dec_word), .src_reg(src_reg), .dst_reg(dst_reg), .src_mode(src_mode),
    .dst_mode(dst_mode), .second_src_post_inc(second_src_post_inc),
    .multiply_accum_high_we(multiply_accum_high_we), .multiply_accum_low_we(multiply_accum_low_we),
    .disp4(disp4), .disp8(disp8), .disp12(disp12), .imm8(imm8), .imm_value(imm_value),
    .trap_always_offset(trap_always_offset), .branch_target(branch_target),
    .pc_operand_addr(pc_operand_addr));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_fmt(input instruction_format_decoder_pkg::format_t exp);
    chk("dec_format", {20'h0, exp}, {20'h0, dec_format});
  endtask : chk_fmt
  task automatic chk_mode(input string what, input instruction_format_decoder_pkg::operand_t exp,
                          input instruction_format_decoder_pkg::operand_t got);
    chk(what, {28'h0, exp}, {28'h0, got});
  endtask : chk_mode
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // answer comes one cycle after the word is taken
  task automatic send(input logic [15:0] w, input logic [31:0] p);
    @(posedge clk_sys);
    req <= 1'b1;
    req_word <= w;
    req_pc <= p;
    @(posedge clk_sys);
    req <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("dec_valid", 32'h1, {31'h0, dec_valid});
    chk("dec_word", {16'h0, w}, {16'h0, dec_word});
  endtask : send
  task automatic t_branch;
    send(16'ha123, 32'h100);
    chk_fmt(instruction_format_decoder_pkg::FMT_D12);
    chk("disp12", 32'h123, {20'h0, disp12});
    chk("fields", 32'h32323, {12'h0, disp4, disp8, imm8});
    chk("branch_target", 32'h346, branch_target);
    send(16'ha800, 32'h1000);
    chk("branch_target", 32'h0, branch_target);
    send(16'hafff, 32'h200);
    chk("branch_target", 32'h1fe, branch_target);
  endtask : t_branch
  task automatic t_single_src;
    logic [15:0] w[4] = '{16'h4317, 16'h4a2b, 16'h4e0e, 16'h0523};
    instruction_format_decoder_pkg::operand_t m[4] = '{instruction_format_decoder_pkg::OPND_POST_INC,
      instruction_format_decoder_pkg::OPND_INDIRECT, instruction_format_decoder_pkg::OPND_REG,
      instruction_format_decoder_pkg::OPND_PC_REL_REG};
    for (int i = 0; i < 4; i++) begin
      send(w[i], 32'h80);
      chk_fmt(instruction_format_decoder_pkg::FMT_M);
      chk("src_reg", {28'h0, w[i][11:8]}, {28'h0, src_reg});
      chk_mode("src_mode", m[i], src_mode);
    end
  endtask : t_single_src
  task automatic t_single_dst;
    send(16'h0b0a, 32'h0);
    chk_fmt(instruction_format_decoder_pkg::FMT_N);
    chk("dst_reg", 32'hb, {28'h0, dst_reg});
    chk_mode("dst_mode", instruction_format_decoder_pkg::OPND_REG, dst_mode);
    chk_mode("src_mode", instruction_format_decoder_pkg::OPND_CTRL_SYS, src_mode);
    send(16'h4c03, 32'h0);
    chk_mode("dst_mode", instruction_format_decoder_pkg::OPND_PRE_DEC, dst_mode);
    chk_mode("src_mode", instruction_format_decoder_pkg::OPND_CTRL_SYS, src_mode);
  endtask : t_single_dst
  task automatic t_mac;
    send(16'h4a5f, 32'h0);
    chk("dst_reg", 32'ha, {28'h0, dst_reg});
    chk("accum_we", 32'h7, {29'h0, second_src_post_inc, multiply_accum_high_we,
      multiply_accum_low_we});
    send(16'h3a5c, 32'h0);
    chk("accum_we", 32'h0, {29'h0, second_src_post_inc, multiply_accum_high_we,
      multiply_accum_low_we});
  endtask : t_mac
  task automatic t_pc_rel;
    send(16'hd3ff, 32'h1003);
    chk("pc_operand_addr", 32'h13fc, pc_operand_addr);
    send(16'hc701, 32'h7);
    chk("pc_operand_addr", 32'h8, pc_operand_addr);
    send(16'h9280, 32'h2001);
    chk("pc_operand_addr", 32'h2101, pc_operand_addr);
  endtask : t_pc_rel
  task automatic t_imm;
    logic [15:0] w[6] = '{16'hc310, 16'hc3ff, 16'he180, 16'h7c7f, 16'h88fe, 16'hc9ff};
    logic [31:0] e[6] = '{32'h40, 32'h3fc, 32'hffffff80, 32'h7f, 32'hfffffffe, 32'hff};
    for (int i = 0; i < 2; i++) begin
      send(w[i], 32'h0);
      chk_fmt(instruction_format_decoder_pkg::FMT_I);
      chk("trap_always_offset", e[i], trap_always_offset);
    end
    for (int i = 2; i < 6; i++) begin
      send(w[i], 32'h0);
      chk("imm_value", e[i], imm_value);
    end
  endtask : t_imm
  task automatic t_back;
    @(posedge clk_sys);
    req <= 1'b1;
    req_word <= 16'h6a53;
    req_pc <= 32'h40;
    @(posedge clk_sys);
    req_word <= 16'h2b36;
    @(posedge clk_sys);
    req <= 1'b0;
    @(negedge clk_sys);
    chk("dec_word", 32'h6a53, {16'h0, dec_word});
    @(negedge clk_sys);
    chk("dec_valid", 32'h1, {31'h0, dec_valid});
    chk("dec_word", 32'h2b36, {16'h0, dec_word});
    @(negedge clk_sys);
    chk("dec_valid", 32'h0, {31'h0, dec_valid});
    chk("dec_word", 32'h2b36, {16'h0, dec_word});
  endtask : t_back
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    req_word = 16'h0;
    req_pc = 32'h0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("dec_word", 32'h9, {16'h0, dec_word});
    chk_fmt(instruction_format_decoder_pkg::FMT_ZERO);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_branch();
    t_single_src();
    t_single_dst();
    t_mac();
    t_pc_rel();
    t_imm();
    t_back();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
